//--- seq_pkg.sv
// Shared constants for the averaging sequencer and its host controller
package seq_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_TIME_NS = 3440;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DTEMP_TIME_US = 50;
  localparam int DTEMP_CYCLES = DTEMP_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int AUTO_TIME_MS = 1000;
  localparam int AUTO_CYCLES = AUTO_TIME_MS * 100000;
  localparam int HS_PER_NS = 12600;
  localparam int GEN_MIN_NS = 4130;
  localparam int CELL_FIRST_US = 60;
  localparam int MON_FIRST_US = 1000;
  localparam logic [16:0] HS_PER_CYC = 17'(HS_PER_NS / CLK_PERIOD_NS);
  localparam logic [16:0] GEN_MIN_CYC =
    17'((GEN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [16:0] CELL_FIRST_CYC =
    17'(CELL_FIRST_US * 1000 / CLK_PERIOD_NS);
  localparam logic [16:0] MON_FIRST_CYC =
    17'(MON_FIRST_US * 1000 / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Channel positions in sequence order
  // ----------------------------------------------------------------
  localparam int NUM_POS = 30;
  localparam logic [4:0] POS_AUX0 = 5'h10;
  localparam logic [4:0] POS_DTEMP = 5'h18;
  localparam logic [4:0] POS_ATEMP = 5'h19;
  localparam logic [4:0] POS_CORE = 5'h1a;
  localparam logic [4:0] POS_REF = 5'h1b;
  localparam logic [4:0] POS_MON = 5'h1c;
  localparam logic [4:0] POS_NEG = 5'h1d;
  localparam logic [2:0] OVS_MAX_CODE = 3'h4;
  // ----------------------------------------------------------------
  // Software register offsets in the host controller
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CELL = 8'h01;
  localparam logic [7:0] REG_SEL = 8'h02;
  localparam logic [7:0] REG_GEN_PER = 8'h03;
  localparam logic [7:0] REG_CELL_PER = 8'h04;
  localparam logic [7:0] REG_AUX_PER = 8'h05;
  localparam logic [7:0] REG_MON_PER = 8'h06;
  localparam logic [7:0] REG_NEG_PER = 8'h07;
  localparam logic [7:0] REG_INT_PER = 8'h08;
  localparam logic [7:0] REG_THRESH = 8'h09;
  localparam logic [7:0] REG_STATUS = 8'h0a;
  localparam logic [7:0] REG_RESULT0 = 8'h20;
  localparam logic [15:0] THRESH_RESET = 16'hffff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_TRACK = 2'b10,
    ST_HOLD = 2'b11
  } seq_state_t;
endpackage

//--- seq_link_if.sv
// Link between the host controller and the averaging sequencer
`timescale 1ns/1ps
interface seq_link_if;
  logic start;
  logic broadcast;
  logic averaging_order_sel;
  logic [2:0] oversample_config;
  logic module_monitor_enable;
  logic digital_temp_select;
  logic [15:0] cell_mask;
  logic [4:0] cell_count_config;
  logic [7:0] aux_mask;
  logic [4:0] int_mask;
  logic [16:0] high_side_oversample_period;
  logic [16:0] general_oversample_period;
  logic [16:0] cell_first_sample_period;
  logic [16:0] aux_first_sample_period;
  logic [16:0] module_first_period;
  logic [16:0] neg_supply_first_period;
  logic [16:0] internal_first_period;
  logic [15:0] temp_threshold;
  logic rd_req;
  logic [4:0] rd_addr;
  logic [15:0] rd_data;
  logic busy;
  logic done;
  logic temp_fault;

  modport dev (
    input start, broadcast, averaging_order_sel, oversample_config,
    module_monitor_enable, digital_temp_select, cell_mask,
    cell_count_config, aux_mask, int_mask, high_side_oversample_period,
    general_oversample_period, cell_first_sample_period,
    aux_first_sample_period, module_first_period, neg_supply_first_period,
    internal_first_period, temp_threshold, rd_req, rd_addr,
    output rd_data, busy, done, temp_fault
  );
  modport host (
    output start, broadcast, averaging_order_sel, oversample_config,
    module_monitor_enable, digital_temp_select, cell_mask,
    cell_count_config, aux_mask, int_mask, high_side_oversample_period,
    general_oversample_period, cell_first_sample_period,
    aux_first_sample_period, module_first_period, neg_supply_first_period,
    internal_first_period, temp_threshold, rd_req, rd_addr,
    input rd_data, busy, done, temp_fault
  );
endinterface

//--- seq_host.sv
// Host controller: software registers that drive the sequencer link
`timescale 1ns/1ps
module seq_host (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  seq_link_if.host link
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [20:0] cell_q, cell_d;
  logic [13:0] sel_q, sel_d;
  logic [16:0] gen_q, gen_d, cper_q, cper_d, aper_q, aper_d;
  logic [16:0] mper_q, mper_d, nper_q, nper_d, iper_q, iper_d;
  logic [15:0] thr_q, thr_d;
  logic start_q, start_d, bc_q, bc_d, res_q, res_d;
  logic [31:0] loc_q, loc_d;
  logic [16:0] gw;

  // Register writes; general period held inside its legal window
  always_comb
  begin
    ctrl_d = ctrl_q; cell_d = cell_q; sel_d = sel_q; gen_d = gen_q;
    cper_d = cper_q; aper_d = aper_q; mper_d = mper_q; nper_d = nper_q;
    iper_d = iper_q; thr_d = thr_q; start_d = 1'b0; bc_d = bc_q;
    gw = wdata[16:0];
    if (wr_stb)
    begin
      if (addr == seq_pkg::REG_CTRL)
      begin
        ctrl_d = wdata[7:0];
        start_d = wdata[8]; // RL12
        bc_d = wdata[9];
      end
      else if (addr == seq_pkg::REG_CELL) cell_d = wdata[20:0];
      else if (addr == seq_pkg::REG_SEL) sel_d = wdata[13:0];
      else if (addr == seq_pkg::REG_GEN_PER)
      begin
        if (gw < seq_pkg::GEN_MIN_CYC) gen_d = seq_pkg::GEN_MIN_CYC; // RL9
        else if (gw > seq_pkg::HS_PER_CYC) gen_d = seq_pkg::HS_PER_CYC;
        else gen_d = gw;
      end
      else if (addr == seq_pkg::REG_CELL_PER) cper_d = gw;
      else if (addr == seq_pkg::REG_AUX_PER) aper_d = gw;
      else if (addr == seq_pkg::REG_MON_PER) mper_d = gw;
      else if (addr == seq_pkg::REG_NEG_PER) nper_d = gw;
      else if (addr == seq_pkg::REG_INT_PER) iper_d = gw;
      else if (addr == seq_pkg::REG_THRESH) thr_d = wdata[15:0];
    end
  end

  // Read path: local registers or a result fetched over the link
  always_comb
  begin
    res_d = rd_stb && (addr >= seq_pkg::REG_RESULT0) &&
            (addr < seq_pkg::REG_RESULT0 + 8'(seq_pkg::NUM_POS));
    loc_d = 32'h0;
    if (addr == seq_pkg::REG_CTRL) loc_d = {24'h0, ctrl_q};
    else if (addr == seq_pkg::REG_CELL) loc_d = {11'h0, cell_q};
    else if (addr == seq_pkg::REG_SEL) loc_d = {18'h0, sel_q};
    else if (addr == seq_pkg::REG_GEN_PER) loc_d = {15'h0, gen_q};
    else if (addr == seq_pkg::REG_CELL_PER) loc_d = {15'h0, cper_q};
    else if (addr == seq_pkg::REG_AUX_PER) loc_d = {15'h0, aper_q};
    else if (addr == seq_pkg::REG_MON_PER) loc_d = {15'h0, mper_q};
    else if (addr == seq_pkg::REG_NEG_PER) loc_d = {15'h0, nper_q};
    else if (addr == seq_pkg::REG_INT_PER) loc_d = {15'h0, iper_q};
    else if (addr == seq_pkg::REG_THRESH) loc_d = {16'h0, thr_q};
    else if (addr == seq_pkg::REG_STATUS)
      loc_d = {30'h0, link.temp_fault, link.busy};
  end

  // Registers; cell and module first periods reset to recommended values, the others to the high-side period
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= 8'h0; cell_q <= 21'h0; sel_q <= 14'h0;
      gen_q <= seq_pkg::HS_PER_CYC;
      cper_q <= seq_pkg::CELL_FIRST_CYC; // RL21
      aper_q <= seq_pkg::HS_PER_CYC;
      mper_q <= seq_pkg::MON_FIRST_CYC; // RL21
      nper_q <= seq_pkg::HS_PER_CYC; iper_q <= seq_pkg::HS_PER_CYC;
      thr_q <= seq_pkg::THRESH_RESET; start_q <= 1'b0; bc_q <= 1'b0;
      res_q <= 1'b0; loc_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d; cell_q <= cell_d; sel_q <= sel_d; gen_q <= gen_d;
      cper_q <= cper_d; aper_q <= aper_d; mper_q <= mper_d;
      nper_q <= nper_d; iper_q <= iper_d; thr_q <= thr_d;
      start_q <= start_d; bc_q <= bc_d; res_q <= res_d;
      loc_q <= rd_stb ? loc_d : 32'h0;
    end
  end

  // Link drive
  assign link.start = start_q;
  assign link.broadcast = bc_q; // RL13
  assign link.averaging_order_sel = ctrl_q[0];
  assign link.oversample_config = ctrl_q[3:1];
  assign link.module_monitor_enable = ctrl_q[4];
  assign link.digital_temp_select = ctrl_q[5];
  assign link.cell_mask = cell_q[15:0];
  assign link.cell_count_config = cell_q[20:16];
  assign link.aux_mask = sel_q[7:0];
  assign link.int_mask = sel_q[12:8];
  assign link.high_side_oversample_period = seq_pkg::HS_PER_CYC; // RL9
  assign link.general_oversample_period = gen_q;
  assign link.cell_first_sample_period = cper_q;
  assign link.aux_first_sample_period = aper_q;
  assign link.module_first_period = mper_q;
  assign link.neg_supply_first_period = nper_q;
  assign link.internal_first_period = iper_q;
  assign link.temp_threshold = thr_q;
  assign link.rd_req = res_d;
  assign link.rd_addr = 5'(addr - seq_pkg::REG_RESULT0);
  assign rdata = res_q ? {16'h0, link.rd_data} : loc_q;
endmodule

//--- seq_device.sv
// Averaging measurement sequencer for the battery-monitor converter
// Overview of operation
// RL1 - Oversample count two to thirty-two
// RL2 - Average samples into one 16-bit result
// RL3 - Order: cells, then aux, then internal
// RL4 - Cycled mode: one sample per channel pass
// RL5 - Non-cycled: all samples per channel consecutively
// RL6 - First sample uses its own period
// RL7 - Later cell/aux period depends on mode
// RL8 - Internal later samples: high-side or general
// RL9 - Host fixes high-side, bounds general period
// RL10 - Digital temp unaveraged, timing still oversampled
// RL11 - Module monitor does two or one conversions
// RL12 - Command write starts the sequence
// RL13 - Broadcast start is simultaneous for all
// RL14 - Full scale code means twice reference
// RL15 - Module channel divided by twenty-five
// RL16 - Digital temp only when selected, voltage
// RL17 - Fault flag recomputed from stored temperature
// RL18 - Timer samples digital temp every second
// RL19 - Temp-sampling command restarts the timer
// RL20 - Command preempts auto sample, which reruns
// RL21 - Host recommended first sample periods
// RL22 - Cells sampled highest first, downward
// RL23 - Fixed hold per conversion after tracking
// RL24 - Latest result per channel stored, readable
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module seq_device #(
  parameter int DTEMP_CYC = seq_pkg::DTEMP_CYCLES,
  parameter int AUTO_CYC = seq_pkg::AUTO_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [13:0] adc_data,
  output logic [4:0] conv_channel,
  output logic conv_sample,
  seq_link_if.dev link
);
  seq_pkg::seq_state_t state_q, state_d;
  logic [4:0] pos_q, pos_d;
  logic [5:0] samp_q, samp_d;
  logic [16:0] cnt_q, cnt_d;
  logic [2:0] ovs_q, ovs_d;
  logic cyc_q, cyc_d, mon_q, mon_d, dts_q, dts_d, auto_q, auto_d;
  logic conv2_q, conv2_d, pend_q, pend_d, done_q, done_d;
  logic [26:0] tmr_q, tmr_d;
  logic [18:0] acc_q [seq_pkg::NUM_POS];
  logic [15:0] res_q [seq_pkg::NUM_POS];
  logic [15:0] rdat_q, fault_q;
  logic fault_bit_q;
  logic [5:0] nsamp;
  logic [18:0] sum;
  logic [20:0] scaled;
  logic [15:0] avg;
  logic cap, last, start_cmd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Samples per average from the oversample code
  function automatic logic [5:0] samples(input logic [2:0] code);
    logic [2:0] c;
    c = (code > seq_pkg::OVS_MAX_CODE) ? seq_pkg::OVS_MAX_CODE : code;
    samples = 6'h2 << c; // RL1
  endfunction

  // Channel selected at a sequence position
  function automatic logic selected(input logic [4:0] p, input logic au);
    logic s;
    s = 1'b0;
    if (au) s = (p == seq_pkg::POS_DTEMP);
    else if (p < seq_pkg::POS_AUX0)
      s = link.cell_mask[4'(15 - p)] && // RL22
          (5'(16 - p) <= link.cell_count_config);
    else if (p < seq_pkg::POS_DTEMP) s = link.aux_mask[3'(p)];
    else if (p == seq_pkg::POS_DTEMP) s = link.digital_temp_select; // RL16
    else if (p <= seq_pkg::POS_NEG) s = link.int_mask[3'(p - 5'h19)];
    selected = s;
  endfunction

  // Tracking period for a position and sample index
  function automatic logic [16:0] period(input logic [4:0] p,
                                         input logic [5:0] n,
                                         input logic cy);
    logic [16:0] v;
    v = link.high_side_oversample_period; // RL8
    if (n == 6'h0)
    begin
      // RL6
      if (p < seq_pkg::POS_AUX0) v = link.cell_first_sample_period;
      else if (p < seq_pkg::POS_DTEMP) v = link.aux_first_sample_period;
      else if (p == seq_pkg::POS_DTEMP) v = 17'(DTEMP_CYC); // RL10
      else if (p == seq_pkg::POS_MON) v = link.module_first_period;
      else if (p == seq_pkg::POS_NEG) v = link.neg_supply_first_period;
      else v = link.internal_first_period;
    end
    else if (p < seq_pkg::POS_AUX0) // RL7
      v = cy ? link.cell_first_sample_period
             : link.high_side_oversample_period;
    else if (p < seq_pkg::POS_DTEMP)
      v = cy ? link.aux_first_sample_period
             : link.general_oversample_period;
    else if (p == seq_pkg::POS_CORE) v = link.general_oversample_period;
    period = (v == 17'h0) ? 17'h0 : v - 17'h1;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign nsamp = auto_q ? 6'h1 : samples(ovs_q);
  assign last = (samp_q == nsamp - 6'h1);
  assign cap = (state_q == seq_pkg::ST_HOLD) && (cnt_q == 17'h0) && !conv2_q;
  assign start_cmd = link.start; // RL12 RL13

  // Next state of the walk over positions and samples
  always_comb
  begin
    state_d = state_q; pos_d = pos_q; samp_d = samp_q; cnt_d = cnt_q;
    ovs_d = ovs_q; cyc_d = cyc_q; mon_d = mon_q; dts_d = dts_q;
    auto_d = auto_q; conv2_d = conv2_q; done_d = 1'b0;
    if (start_cmd && (state_q == seq_pkg::ST_IDLE || auto_q)) // RL20
    begin
      state_d = seq_pkg::ST_SEEK; pos_d = 5'h0; samp_d = 6'h0; // RL3
      ovs_d = link.oversample_config; cyc_d = link.averaging_order_sel;
      mon_d = link.module_monitor_enable; dts_d = link.digital_temp_select;
      auto_d = 1'b0;
    end
    else
    begin
      case (state_q)
        seq_pkg::ST_IDLE:
        begin
          if (pend_q) // RL18
          begin
            state_d = seq_pkg::ST_SEEK; pos_d = seq_pkg::POS_DTEMP;
            samp_d = 6'h0; auto_d = 1'b1; dts_d = 1'b1;
          end
        end
        seq_pkg::ST_SEEK:
        begin
          if (pos_q < 5'(seq_pkg::NUM_POS) && selected(pos_q, auto_q))
          begin
            state_d = seq_pkg::ST_TRACK;
            cnt_d = period(pos_q, samp_q, cyc_q);
          end
          else if (pos_q < 5'(seq_pkg::NUM_POS) - 5'h1 && !auto_q)
            pos_d = pos_q + 5'h1;
          else if (cyc_q && !last && !auto_q) // RL4
          begin
            pos_d = 5'h0; samp_d = samp_q + 6'h1;
          end
          else
          begin
            state_d = seq_pkg::ST_IDLE; done_d = !auto_q; auto_d = 1'b0;
          end
        end
        seq_pkg::ST_TRACK:
        begin
          if (cnt_q != 17'h0) cnt_d = cnt_q - 17'h1;
          else
          begin
            state_d = seq_pkg::ST_HOLD; // RL23
            cnt_d = 17'(seq_pkg::HOLD_CYCLES - 1);
            conv2_d = mon_q && (pos_q == seq_pkg::POS_MON); // RL11
          end
        end
        default:
        begin
          if (cnt_q != 17'h0) cnt_d = cnt_q - 17'h1;
          else if (conv2_q)
          begin
            conv2_d = 1'b0; cnt_d = 17'(seq_pkg::HOLD_CYCLES - 1); // RL11
          end
          else if (!cyc_q && !last) // RL5
          begin
            state_d = seq_pkg::ST_TRACK; samp_d = samp_q + 6'h1;
            cnt_d = period(pos_q, samp_q + 6'h1, cyc_q);
          end
          else
          begin
            state_d = seq_pkg::ST_SEEK;
            if (cyc_q) pos_d = pos_q + 5'h1;
            else
            begin
              pos_d = pos_q + 5'h1; samp_d = 6'h0;
            end
          end
        end
      endcase
    end
  end

  // Auto temperature timer and pending request
  // Timer runs free so autos stay one period apart; expiry beats the auto completion clear, a temp-select command clear beats expiry
  always_comb
  begin
    tmr_d = tmr_q + 27'h1;
    pend_d = pend_q;
    if (auto_q && cap) pend_d = 1'b0; // RL20
    if (tmr_q >= 27'(AUTO_CYC - 1))
    begin
      tmr_d = 27'h0; pend_d = 1'b1; // RL18
    end
    if (start_cmd && link.digital_temp_select &&
        (state_q == seq_pkg::ST_IDLE || auto_q))
    begin
      tmr_d = 27'h0; pend_d = 1'b0; // RL19
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= seq_pkg::ST_IDLE; pos_q <= 5'h0; samp_q <= 6'h0;
      cnt_q <= 17'h0; ovs_q <= 3'h0; cyc_q <= 1'b0; mon_q <= 1'b0;
      dts_q <= 1'b0; auto_q <= 1'b0; conv2_q <= 1'b0; done_q <= 1'b0;
      tmr_q <= 27'h0; pend_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d; pos_q <= pos_d; samp_q <= samp_d; cnt_q <= cnt_d;
      ovs_q <= ovs_d; cyc_q <= cyc_d; mon_q <= mon_d; dts_q <= dts_d;
      auto_q <= auto_d; conv2_q <= conv2_d; done_q <= done_d;
      tmr_q <= tmr_d; pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Accumulation and results
  // ----------------------------------------------------------------
  // Sum scaled to 16 bits: times four, divided by sample count
  always_comb
  begin
    sum = (samp_q == 6'h0) ? {5'h0, adc_data}
                           : acc_q[pos_q] + {5'h0, adc_data};
    scaled = {sum, 2'b00} >> (ovs_q > seq_pkg::OVS_MAX_CODE ?
                              3'h5 : ovs_q + 3'h1);
    avg = scaled[15:0]; // RL2 RL14 RL15
    if (pos_q == seq_pkg::POS_DTEMP || auto_q) avg = {adc_data, 2'b00};
  end

  // Accumulators and stored results, one per position
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < seq_pkg::NUM_POS; i++)
      begin
        acc_q[i] <= 19'h0;
        res_q[i] <= 16'h0;
      end
      rdat_q <= 16'h0; fault_bit_q <= 1'b0;
    end
    else
    begin
      if (cap)
      begin
        acc_q[pos_q] <= sum;
        // RL10
        if (pos_q == seq_pkg::POS_DTEMP)
        begin
          if (samp_q == 6'h0) res_q[pos_q] <= avg;
        end
        else if (last) res_q[pos_q] <= avg; // RL24
      end
      if (link.rd_req) rdat_q <= (link.rd_addr < 5'(seq_pkg::NUM_POS)) ?
                                 res_q[link.rd_addr] : 16'h0;
      fault_bit_q <= res_q[seq_pkg::POS_DTEMP] > link.temp_threshold; // RL17
    end
  end

  assign conv_channel = pos_q;
  assign conv_sample = cap;
  assign link.rd_data = rdat_q;
  assign link.busy = (state_q != seq_pkg::ST_IDLE) && !auto_q;
  assign link.done = done_q;
  assign link.temp_fault = fault_bit_q;
endmodule

//--- seq_link_properties.sv
// Concurrent checks on the host to sequencer link
`timescale 1ns/1ps
module seq_link_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic temp_fault,
  input wire logic [15:0] temp_threshold
);
  // ----------------------------------------------------------
  // Command start, completion and fault flag
  // ----------------------------------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_start_pulse: assert property (start |=> !start)
    else $error("start held past one cycle");
  a_start_runs: assert property (start && !busy |=> busy [*8])
    else $error("idle start did not run");
  a_busy_cause: assert property ($rose(busy) |-> $past(start))
    else $error("busy rose without start");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_after_run: assert property (done |-> $past(busy))
    else $error("done without a run");
  a_done_idle: assert property (done |-> !busy)
    else $error("busy during done");
  a_end_gives_done: assert property ($fell(busy) |-> done)
    else $error("run ended without done");
  a_fault_top: assert property ((&temp_threshold) |=> !temp_fault)
    else $error("fault above top threshold");
  // Main scenarios reached
  c_run: cover property (start && !busy);
  c_done: cover property (done);
  c_fault: cover property ($rose(temp_fault));
endmodule

//--- tb.sv
// Self-checking bench for host controller and sequencer together
`timescale 1ns/1ps
module tb;
  localparam int AUTO = 2000;
  logic sys_clk;
  logic rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rdata;
  logic [13:0] adc_data;
  logic [4:0] conv_channel;
  logic conv_sample;
  logic [31:0] xs_q = 32'h38;
  logic [13:0] smp[30][$];
  int obs[$];
  int err_total;
  int n_checks;
  int cyc;
  int auto_n;
  int t0;
  int a0;
  seq_link_if lnk ();
  seq_host seq_host_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .link(lnk)
  );
  seq_device #(.DTEMP_CYC(20), .AUTO_CYC(AUTO)) seq_device_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .adc_data(adc_data),
    .conv_channel(conv_channel),
    .conv_sample(conv_sample),
    .link(lnk)
  );
  seq_link_properties seq_link_properties_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(lnk.start),
    .busy(lnk.busy),
    .done(lnk.done),
    .temp_fault(lnk.temp_fault),
    .temp_threshold(lnk.temp_threshold)
  );
  // ----------------------------------------------------------
  // Clock, converter data, capture and helpers
  // ----------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Xorshift step for converter data
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    xorshift = r ^ (r << 5);
  endfunction
  // Random converter data, changed just after each rising edge
  always @(posedge sys_clk)
  begin
    cyc++;
    xs_q = xorshift(xs_q);
    adc_data <= xs_q[13:0];
  end
  // Records every kept conversion while the outputs are settled
  always @(negedge sys_clk)
  begin
    if (conv_sample === 1'b1 && conv_channel < 5'h1e)
    begin
      if (conv_channel != seq_pkg::POS_DTEMP)
        obs.push_back(conv_channel);
      else if (lnk.busy === 1'b0)
        auto_n++;
      smp[conv_channel].push_back(adc_data);
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Runs one command; model predicts order and averaged results
  task automatic run(int t, logic [31:0] ctl, logic [31:0] cr,
                     logic [31:0] sr);
    int sel[$];
    int ex[$];
    int k;
    int n;
    int e;
    logic [31:0] d;
    k = ctl[3:1] + 1;
    n = 1 << k;
    for (int p = 0; p < 16; p++)
      if (cr[15 - p] && (16 - p) <= cr[20:16])
        sel.push_back(p);
    for (int i = 0; i < 13; i++)
      if (sr[i])
        sel.push_back(i < 8 ? 16 + i : 17 + i);
    for (int s = 0; s < n * sel.size(); s++)
      ex.push_back(ctl[0] ? sel[s % sel.size()] : sel[s / n]);
    wr(seq_pkg::REG_CELL, cr);
    wr(seq_pkg::REG_SEL, sr);
    obs.delete();
    foreach (smp[i])
      smp[i].delete();
    wr(seq_pkg::REG_CTRL, ctl | 32'h100);
    t0 = cyc;
    a0 = auto_n;
    rd(seq_pkg::REG_STATUS, d);
    chk("busy", d[0], 1'b1);
    for (int w = 0; w < 40000 && lnk.done !== 1'b1; w++)
      @(negedge sys_clk);
    chk("done", lnk.done, 1'b1);
    chk("count", obs.size(), ex.size());
    foreach (ex[i])
      chk("order", i < obs.size() ? obs[i] : -1, ex[i]);
    if (ctl[5])
      sel.push_back(24);
    foreach (sel[j])
    begin
      e = 0;
      for (int i = 0; i < smp[sel[j]].size(); i++)
        e += smp[sel[j]][i];
      e = sel[j] == 24 ? smp[24][0] << 2 : (e << 2) >> k;
      rd(seq_pkg::REG_RESULT0 + 8'(sel[j]), d);
      chk("result", d, e);
    end
    $display("test %0d done", t);
  endtask
  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    adc_data = 14'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(seq_pkg::REG_STATUS, d);
    chk("status", d, 32'h0);
    rd(8'h15, d);
    chk("unmapped", d, 32'h0);
    for (int a = 4; a <= 8; a++)
      wr(8'(a), 32'h14);
    wr(seq_pkg::REG_GEN_PER, 32'h19d);
    wr(seq_pkg::REG_THRESH, 32'h0);
    run(1, 32'h233, 32'h0010_8204, 32'h0908);
    rd(seq_pkg::REG_STATUS, d);
    chk("fault", d[1], smp[24][0] != 14'h0);
    wr(seq_pkg::REG_THRESH, 32'hffff);
    rd(seq_pkg::REG_STATUS, d);
    chk("fault", d[1], 1'b0);
    run(2, 32'h000, 32'h000d_3800, 32'h1681);
    for (int c = 0; c < 5; c++)
      run(3 + c, {28'h0, 3'(c), 1'b1}, 32'h0010_0001, 32'h0);
    repeat (500) @(negedge sys_clk);
    chk("pending auto", auto_n > a0, 1'b1);
    run(8, 32'h20, 32'h0, 32'h0);
    while (cyc < t0 + 3 * AUTO + AUTO / 2)
      @(negedge sys_clk);
    chk("auto count", auto_n - a0, 3);
    conclude();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    conclude();
  end
endmodule
